// file: enclave_page_permission_extender.sv
// Permission extension leaf engine with its register port.
`timescale 1ns/10ps
`default_nettype none
module enclave_page_permission_extender (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o,
   input wire logic leaf_req_i,
   input wire perm_ext_pkg::leaf_t leaf_i,
   input wire perm_ext_pkg::env_t env_i,
   output logic busy_o,
   output logic acc_req_o,
   output logic acc_meta_o,
   output logic [63:0] acc_addr_o,
   input wire logic acc_ack_i,
   input wire perm_ext_pkg::resp_t acc_resp_i,
   output logic lock_req_o,
   input wire logic lock_ack_i,
   input wire logic lock_busy_i,
   output logic lock_rel_o,
   output logic meta_wr_o,
   output logic [2:0] meta_rwx_o,
   output logic done_o,
   output logic gp_o,
   output logic pf_o,
   output logic [63:0] fault_addr_o,
   output logic [31:0] err_code_o
);

   typedef struct packed {
      perm_ext_pkg::state_t st;
      perm_ext_pkg::leaf_t leaf;
      logic [511:0] scratch;
      perm_ext_pkg::meta_t dmeta;
      perm_ext_pkg::meta_t tmeta;
      logic depc;
      logic tepc;
      logic fgp;
      logic fpf;
      logic locked;
      logic [63:0] faddr;
      logic [31:0] ecode;
      logic en;
      logic [2:0] status;
      logic [2:0] mask;
      logic [15:0] count;
      logic [31:0] rdata;
      logic irq;
      logic busy;
      logic acc_req;
      logic acc_meta;
      logic [63:0] acc_addr;
      logic lock_req;
      logic lock_rel;
      logic meta_wr;
      logic [2:0] rwx;
      logic done;
      logic gp;
      logic pf;
   } regs_t;

   regs_t q_r;
   regs_t q_nxt;

   // Canonical form in 64-bit mode, segment limit otherwise.
   function automatic logic addr_ok(input logic [63:0] a, input logic [63:0] sz_m1,
                                    input perm_ext_pkg::env_t e);
      logic [63:0] last;
      last = a + sz_m1;
      if (e.mode64) begin
         addr_ok = (a[63:perm_ext_pkg::VA_TOP] == '0) ||
                   (a[63:perm_ext_pkg::VA_TOP] == '1);
      end else begin
         addr_ok = (a[63:32] == 32'h0) && (last <= {32'h0, e.seg_limit});
      end
   endfunction

   function automatic logic in_range(input logic [63:0] a, input logic [63:0] sz_m1,
                                     input perm_ext_pkg::env_t e);
      logic [63:0] last;
      last = a + sz_m1;
      in_range = (a >= e.el_base) && (last <= e.el_limit) && (last >= a);
   endfunction

   // Common page metadata test; need_r, chk_blk and chk_lin pick the variant.
   function automatic logic meta_ok(input perm_ext_pkg::meta_t m, input logic [63:0] act,
                                    input logic need_r, input logic chk_blk,
                                    input logic chk_lin, input logic [63:0] lin);
      meta_ok = m.valid && !m.pending && !m.modified &&
                (m.pt == perm_ext_pkg::REGULAR_PAGE_TYPE) && (m.owner == act) &&
                (!need_r || m.r) && (!chk_blk || !m.blocked) &&
                (!chk_lin || (m.lin == lin));
   endfunction

   always_comb begin
      logic [2:0] set;
      logic [2:0] clr;
      set = 3'h0;
      clr = 3'h0;
      q_nxt = q_r;
      q_nxt.lock_rel = 1'b0;
      q_nxt.meta_wr = 1'b0;
      q_nxt.done = 1'b0;
      q_nxt.gp = 1'b0;
      q_nxt.pf = 1'b0;
      q_nxt.rdata = 32'h0;

      case (q_r.st)
         perm_ext_pkg::S_IDLE: begin
            // A disabled engine ignores leaf requests; the core must not issue one.
            if (leaf_req_i && q_r.en && leaf_i.sel == perm_ext_pkg::LEAF_EXTEND) begin
               q_nxt.leaf = leaf_i;
               q_nxt.busy = 1'b1;
               q_nxt.fgp = 1'b0;
               q_nxt.fpf = 1'b0;
               q_nxt.locked = 1'b0;
               q_nxt.st = perm_ext_pkg::S_ADDR;
            end
         end

         perm_ext_pkg::S_ADDR: begin
            // Fault address and code restart at zero with every leaf, even a clean one.
            q_nxt.faddr = 64'h0;
            q_nxt.ecode = perm_ext_pkg::GP_CODE;
            q_nxt.st = perm_ext_pkg::S_FIN;
            q_nxt.fgp = 1'b1;
            if (!env_i.in_enclave) begin
               q_nxt.fgp = 1'b1;
            end else if (!addr_ok(q_r.leaf.base, perm_ext_pkg::DESC_SIZE_M1, env_i) ||
                  !addr_ok(q_r.leaf.count, perm_ext_pkg::PAGE_SIZE_M1, env_i)) begin
               q_nxt.fgp = 1'b1;
            end else if ((q_r.leaf.base & perm_ext_pkg::DESC_SIZE_M1) != 64'h0) begin
               q_nxt.fgp = 1'b1;
            end else if ((q_r.leaf.count & perm_ext_pkg::PAGE_SIZE_M1) != 64'h0) begin
               q_nxt.fgp = 1'b1;
            end else if (!in_range(q_r.leaf.base, perm_ext_pkg::DESC_SIZE_M1, env_i) ||
                  !in_range(q_r.leaf.count, perm_ext_pkg::PAGE_SIZE_M1, env_i)) begin
               q_nxt.fgp = 1'b1;
            end else begin
               // The descriptor is only read, so no lock is taken on it.
               q_nxt.fgp = 1'b0;
               q_nxt.st = perm_ext_pkg::S_QDESC;
               q_nxt.acc_req = 1'b1;
               q_nxt.acc_meta = 1'b1;
               q_nxt.acc_addr = q_r.leaf.base;
            end
         end

         perm_ext_pkg::S_QDESC, perm_ext_pkg::S_QTGT: begin
            if (acc_ack_i) begin
               q_nxt.acc_req = 1'b0;
               if (acc_resp_i.pf) begin
                  q_nxt.fpf = 1'b1;
                  q_nxt.faddr = q_r.acc_addr;
                  q_nxt.ecode = acc_resp_i.pf_code;
                  q_nxt.st = perm_ext_pkg::S_FIN;
               end else if (q_r.st == perm_ext_pkg::S_QDESC) begin
                  q_nxt.dmeta = acc_resp_i.meta;
                  q_nxt.depc = acc_resp_i.in_epc;
                  q_nxt.acc_req = 1'b1;
                  q_nxt.acc_addr = q_r.leaf.count;
                  q_nxt.st = perm_ext_pkg::S_QTGT;
               end else begin
                  q_nxt.tmeta = acc_resp_i.meta;
                  q_nxt.tepc = acc_resp_i.in_epc;
                  q_nxt.st = perm_ext_pkg::S_CHK;
               end
            end
         end

         perm_ext_pkg::S_CHK: begin
            q_nxt.ecode = 32'h0;
            q_nxt.fpf = 1'b1;
            q_nxt.st = perm_ext_pkg::S_FIN;
            // Page-cache membership comes before any trust in the metadata lookups.
            if (!q_r.depc) begin
               q_nxt.faddr = q_r.leaf.base;
            end else if (!q_r.tepc) begin
               q_nxt.faddr = q_r.leaf.count;
            end else if (!meta_ok(q_r.dmeta, env_i.active, 1'b1, 1'b1, 1'b1,
                                  {q_r.leaf.base[63:12], 12'h000})) begin
               q_nxt.faddr = q_r.leaf.base;
            end else begin
               q_nxt.fpf = 1'b0;
               q_nxt.st = perm_ext_pkg::S_RDESC;
               q_nxt.acc_req = 1'b1;
               q_nxt.acc_meta = 1'b0;
               q_nxt.acc_addr = q_r.leaf.base;
            end
         end

         perm_ext_pkg::S_RDESC: begin
            if (acc_ack_i) begin
               q_nxt.acc_req = 1'b0;
               q_nxt.scratch = acc_resp_i.data;
               q_nxt.st = perm_ext_pkg::S_TCHK;
               if (acc_resp_i.pf) begin
                  q_nxt.fpf = 1'b1;
                  q_nxt.faddr = q_r.leaf.base;
                  q_nxt.ecode = acc_resp_i.pf_code;
                  q_nxt.st = perm_ext_pkg::S_FIN;
               end else if ((acc_resp_i.data & perm_ext_pkg::DESC_RSV_MASK) !=
                            512'h0) begin
                  q_nxt.fgp = 1'b1;
                  q_nxt.faddr = 64'h0;
                  q_nxt.ecode = perm_ext_pkg::GP_CODE;
                  q_nxt.st = perm_ext_pkg::S_FIN;
               end
            end
         end

         perm_ext_pkg::S_TCHK: begin
            // The target's recorded address waits for the recheck under the lock.
            if (!meta_ok(q_r.tmeta, env_i.active, 1'b0, 1'b1, 1'b0, 64'h0)) begin
               q_nxt.fpf = 1'b1;
               q_nxt.faddr = q_r.leaf.count;
               q_nxt.ecode = 32'h0;
               q_nxt.st = perm_ext_pkg::S_FIN;
            end else begin
               q_nxt.lock_req = 1'b1;
               q_nxt.st = perm_ext_pkg::S_LOCK;
            end
         end

         perm_ext_pkg::S_LOCK: begin
            if (lock_ack_i) begin
               q_nxt.lock_req = 1'b0;
               // A refused lock was never granted, so this fault skips the release.
               if (lock_busy_i) begin
                  q_nxt.fgp = 1'b1;
                  q_nxt.faddr = 64'h0;
                  q_nxt.ecode = perm_ext_pkg::GP_CODE;
                  q_nxt.st = perm_ext_pkg::S_FIN;
               end else begin
                  q_nxt.locked = 1'b1;
                  q_nxt.acc_req = 1'b1;
                  q_nxt.acc_meta = 1'b1;
                  q_nxt.acc_addr = q_r.leaf.count;
                  q_nxt.st = perm_ext_pkg::S_QRE;
               end
            end
         end

         perm_ext_pkg::S_QRE: begin
            // Metadata may have moved while the lock was pending, so it is read again.
            if (acc_ack_i) begin
               q_nxt.acc_req = 1'b0;
               q_nxt.tmeta = acc_resp_i.meta;
               q_nxt.st = perm_ext_pkg::S_REL;
               if (acc_resp_i.pf) begin
                  q_nxt.fpf = 1'b1;
                  q_nxt.faddr = q_r.leaf.count;
                  q_nxt.ecode = acc_resp_i.pf_code;
               end else if (!acc_resp_i.in_epc ||
                            !meta_ok(acc_resp_i.meta, env_i.active, 1'b0, 1'b0, 1'b1,
                                     q_r.leaf.count)) begin
                  q_nxt.fpf = 1'b1;
                  q_nxt.faddr = q_r.leaf.count;
                  q_nxt.ecode = 32'h0;
               end else if (!acc_resp_i.meta.r && !q_r.scratch[perm_ext_pkg::FLAG_R] &&
                            q_r.scratch[perm_ext_pkg::FLAG_W]) begin
                  q_nxt.fgp = 1'b1;
                  q_nxt.faddr = 64'h0;
                  q_nxt.ecode = perm_ext_pkg::GP_CODE;
               end else begin
                  q_nxt.st = perm_ext_pkg::S_WRITE;
               end
            end
         end

         perm_ext_pkg::S_WRITE: begin
            // Only reached with no fault pending; rights are never cleared.
            q_nxt.meta_wr = 1'b1;
            q_nxt.acc_addr = q_r.leaf.count;
            q_nxt.rwx[perm_ext_pkg::FLAG_R] = q_r.tmeta.r |
                                            q_r.scratch[perm_ext_pkg::FLAG_R];
            q_nxt.rwx[perm_ext_pkg::FLAG_W] = q_r.tmeta.w |
                                            q_r.scratch[perm_ext_pkg::FLAG_W];
            q_nxt.rwx[perm_ext_pkg::FLAG_X] = q_r.tmeta.x |
                                            q_r.scratch[perm_ext_pkg::FLAG_X];
            q_nxt.st = perm_ext_pkg::S_REL;
         end

         perm_ext_pkg::S_REL: begin
            // Faults after the grant pass through here too, so no lock is leaked.
            q_nxt.lock_rel = q_r.locked;
            q_nxt.locked = 1'b0;
            q_nxt.st = perm_ext_pkg::S_FIN;
         end

         perm_ext_pkg::S_FIN: begin
            // Each path sets at most one of the fault flags.
            q_nxt.gp = q_r.fgp;
            q_nxt.pf = q_r.fpf;
            q_nxt.done = !q_r.fgp && !q_r.fpf;
            set[perm_ext_pkg::ST_GP] = q_r.fgp;
            set[perm_ext_pkg::ST_PF] = q_r.fpf;
            set[perm_ext_pkg::ST_DONE] = !q_r.fgp && !q_r.fpf;
            q_nxt.count = q_r.count + 16'h0001;
            q_nxt.busy = 1'b0;
            q_nxt.st = perm_ext_pkg::S_IDLE;
         end

         default: begin
            q_nxt.st = perm_ext_pkg::S_IDLE;
            q_nxt.busy = 1'b0;
         end
      endcase

      if (reg_wr_i) begin
         case (reg_addr_i)
            perm_ext_pkg::REG_CTRL: q_nxt.en = reg_wdata_i[perm_ext_pkg::CTRL_EN];
            perm_ext_pkg::REG_STATUS: clr = reg_wdata_i[2:0];
            perm_ext_pkg::REG_MASK: q_nxt.mask = reg_wdata_i[2:0];
            default: q_nxt.en = q_nxt.en;
         endcase
      end

      // A new event wins over a write-one-to-clear in the same cycle.
      q_nxt.status = (q_r.status & ~clr) | set;
      q_nxt.irq = |(q_nxt.status & q_nxt.mask);

      if (reg_rd_i) begin
         case (reg_addr_i)
            perm_ext_pkg::REG_CTRL: q_nxt.rdata = {31'h0, q_r.en};
            perm_ext_pkg::REG_STATUS: q_nxt.rdata = {29'h0, q_r.status};
            perm_ext_pkg::REG_MASK: q_nxt.rdata = {29'h0, q_r.mask};
            perm_ext_pkg::REG_FADDR_LO: q_nxt.rdata = q_r.faddr[31:0];
            perm_ext_pkg::REG_FADDR_HI: q_nxt.rdata = q_r.faddr[63:32];
            perm_ext_pkg::REG_ECODE: q_nxt.rdata = q_r.ecode;
            perm_ext_pkg::REG_STATE: q_nxt.rdata = {27'h0, q_r.busy, q_r.st};
            perm_ext_pkg::REG_COUNT: q_nxt.rdata = {16'h0, q_r.count};
            default: q_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_r <= '0;
         q_r.st <= perm_ext_pkg::S_IDLE;
         q_r.en <= perm_ext_pkg::CTRL_EN_RST;
         q_r.status <= perm_ext_pkg::STATUS_RST;
         q_r.mask <= perm_ext_pkg::MASK_RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign reg_rdata_o = q_r.rdata;
   assign irq_o = q_r.irq;
   assign busy_o = q_r.busy;
   assign acc_req_o = q_r.acc_req;
   assign acc_meta_o = q_r.acc_meta;
   assign acc_addr_o = q_r.acc_addr;
   assign lock_req_o = q_r.lock_req;
   assign lock_rel_o = q_r.lock_rel;
   assign meta_wr_o = q_r.meta_wr;
   assign meta_rwx_o = q_r.rwx;
   assign done_o = q_r.done;
   assign gp_o = q_r.gp;
   assign pf_o = q_r.pf;
   assign fault_addr_o = q_r.faddr;
   assign err_code_o = q_r.ecode;

endmodule
`default_nettype wire

// file: page_store_model.sv
// Behavioural page store and page lock arbiter facing the extender.
`timescale 1ns/10ps
`default_nettype none
module page_store_model (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic acc_req_i,
   input wire logic [63:0] acc_addr_i,
   input wire logic lock_req_i,
   input wire logic [63:0] tgt_addr_i,
   input wire perm_ext_pkg::resp_t dresp_i,
   input wire perm_ext_pkg::resp_t tresp_i,
   input wire logic lock_busy_i,
   input wire logic [3:0] slow_i,
   output logic acc_ack_o,
   output perm_ext_pkg::resp_t acc_resp_o,
   output logic lock_ack_o,
   output logic lock_busy_o
);
   logic [3:0] wait_r;
   // Outside an answer the lines scramble, so a stale sample shows up as garbage.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_r <= 4'h0;
         acc_ack_o <= 1'b0;
         lock_ack_o <= 1'b0;
         lock_busy_o <= 1'b0;
         acc_resp_o <= '0;
      end else begin
         acc_ack_o <= 1'b0;
         lock_ack_o <= 1'b0;
         lock_busy_o <= ~lock_busy_o;
         acc_resp_o <= ~acc_resp_o;
         wait_r <= 4'h0;
         if ((acc_req_i || lock_req_i) && !acc_ack_o && !lock_ack_o) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= slow_i) begin
               acc_ack_o <= acc_req_i;
               lock_ack_o <= lock_req_i && !acc_req_i;
               lock_busy_o <= lock_busy_i;
               acc_resp_o <= (acc_addr_i == tgt_addr_i) ? tresp_i : dresp_i;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: perm_ext_pkg.sv
// Constants and types for the enclave page permission extender.
package perm_ext_pkg;
   localparam logic [63:0] LEAF_EXTEND = 64'h0000_0000_0000_0006;
   localparam logic [63:0] DESC_SIZE_M1 = 64'h0000_0000_0000_003f;
   localparam logic [63:0] PAGE_SIZE_M1 = 64'h0000_0000_0000_0fff;
   localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
   localparam int FLAG_R = 0;
   localparam int FLAG_W = 1;
   localparam int FLAG_X = 2;
   localparam logic [511:0] DESC_RSV_MASK = {{496{1'b1}}, 8'h00, 8'hf8};
   localparam int VA_TOP = 47;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_FADDR_LO = 8'h0c;
   localparam logic [7:0] REG_FADDR_HI = 8'h10;
   localparam logic [7:0] REG_ECODE = 8'h14;
   localparam logic [7:0] REG_STATE = 8'h18;
   localparam logic [7:0] REG_COUNT = 8'h1c;
   localparam int CTRL_EN = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int ST_DONE = 0;
   localparam int ST_GP = 1;
   localparam int ST_PF = 2;
   localparam logic [2:0] STATUS_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;
   localparam logic [31:0] GP_CODE = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic r;
      logic w;
      logic x;
      logic pending;
      logic modified;
      logic blocked;
      logic [7:0] pt;
      logic [63:0] owner;
      logic [63:0] lin;
   } meta_t;

   typedef struct packed {
      logic in_epc;
      logic pf;
      logic [31:0] pf_code;
      meta_t meta;
      logic [511:0] data;
   } resp_t;

   typedef struct packed {
      logic [63:0] sel;
      logic [63:0] base;
      logic [63:0] count;
   } leaf_t;

   typedef struct packed {
      logic in_enclave;
      logic mode64;
      logic [31:0] seg_limit;
      logic [63:0] el_base;
      logic [63:0] el_limit;
      logic [63:0] active;
   } env_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ADDR = 4'h1,
      S_QDESC = 4'h2,
      S_QTGT = 4'h3,
      S_CHK = 4'h4,
      S_RDESC = 4'h5,
      S_TCHK = 4'h6,
      S_LOCK = 4'h7,
      S_QRE = 4'h8,
      S_WRITE = 4'h9,
      S_REL = 4'ha,
      S_FIN = 4'hb
   } state_t;
endpackage

// file: perm_ext_properties.sv
// Port-level assertions for the permission extension engine.
`timescale 1ns/10ps
`default_nettype none
module perm_ext_properties (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic leaf_req_i,
   input wire perm_ext_pkg::leaf_t leaf_i,
   input wire perm_ext_pkg::env_t env_i,
   input wire logic busy_o,
   input wire logic acc_req_o,
   input wire logic [63:0] acc_addr_o,
   input wire logic acc_ack_i,
   input wire perm_ext_pkg::resp_t acc_resp_i,
   input wire logic lock_rel_o,
   input wire logic meta_wr_o,
   input wire logic [2:0] meta_rwx_o,
   input wire logic done_o,
   input wire logic gp_o,
   input wire logic pf_o,
   input wire logic [63:0] fault_addr_o,
   input wire logic [31:0] err_code_o
);
   // The last answer before a write is the recheck, so these are the rights to be widened.
   logic [2:0] old_r;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         old_r <= 3'h0;
      end else if (acc_ack_i) begin
         old_r <= {acc_resp_i.meta.x, acc_resp_i.meta.w, acc_resp_i.meta.r};
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   chk_req_hold: assert property (
      acc_req_o && !acc_ack_i |=> acc_req_o && $stable(acc_addr_o))
      else $error("access request not held");
   chk_one_result: assert property ($onehot0({done_o, gp_o, pf_o}))
      else $error("more than one result pulse");
   chk_gp_zero: assert property (
      gp_o |=> err_code_o == perm_ext_pkg::GP_CODE && fault_addr_o == 64'h0)
      else $error("protection fault code not zero");
   chk_no_late_write: assert property (
      gp_o || pf_o |-> !$past(meta_wr_o) && !$past(meta_wr_o, 2))
      else $error("metadata written before a fault");
   chk_write_order: assert property (meta_wr_o |=> lock_rel_o ##1 done_o)
      else $error("write not followed by release and done");
   chk_rights_widen: assert property (
      meta_wr_o |-> (meta_rwx_o & old_r) == old_r)
      else $error("write clears a right");
   chk_bad_leaf: assert property (
      leaf_req_i && !busy_o && leaf_i.sel != perm_ext_pkg::LEAF_EXTEND |=> !busy_o)
      else $error("foreign leaf taken");
   chk_outside_gp: assert property ($rose(busy_o) && !env_i.in_enclave |-> ##2 gp_o)
      else $error("no fault outside enclave");
   cover property (done_o);
   cover property (gp_o);
   cover property (pf_o);
endmodule
bind enclave_page_permission_extender perm_ext_properties chk_u (.sys_clk_i, .nrst_i,
   .leaf_req_i, .leaf_i, .env_i, .busy_o, .acc_req_o, .acc_addr_o, .acc_ack_i, .acc_resp_i,
   .lock_rel_o, .meta_wr_o, .meta_rwx_o, .done_o, .gp_o, .pf_o, .fault_addr_o, .err_code_o);
`default_nettype wire

// file: tb_enclave_page_permission_extender.sv
// Randomised bench for the permission extension engine.
`timescale 1ns/10ps
`default_nettype none
module tb_enclave_page_permission_extender;
   logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, leaf_req_i, irq_o, busy_o, acc_req_o, acc_meta_o;
   logic acc_ack_i, lock_req_o, lock_ack_i, lock_busy_i, lock_rel_o, meta_wr_o, done_o, gp_o, pf_o;
   logic lb;
   logic [2:0] meta_rwx_o;
   logic [3:0] slow;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, err_code_o;
   logic [63:0] acc_addr_o, fault_addr_o, ba, ct;
   perm_ext_pkg::leaf_t leaf_i;
   perm_ext_pkg::env_t env_i, env;
   perm_ext_pkg::resp_t acc_resp_i, dr, tr;
   int errors, tests_run, seed, k;
   enclave_page_permission_extender dut_u (.*);
   page_store_model store_u (.sys_clk_i, .nrst_i, .acc_req_i(acc_req_o), .acc_addr_i(acc_addr_o),
      .lock_req_i(lock_req_o), .tgt_addr_i(ct), .dresp_i(dr), .tresp_i(tr), .lock_busy_i(lb),
      .slow_i(slow), .acc_ack_o(acc_ack_i), .acc_resp_o(acc_resp_i), .lock_ack_o(lock_ack_i),
      .lock_busy_o(lock_busy_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bound(input int n);
      if (n >= 300) begin
         errors++;
         $display("Error wait bound expected end seen hang");
         complete_run();
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk_val("register", exp, reg_rdata_o);
   endtask
   function automatic logic [98:0] expect_of();
      perm_ext_pkg::meta_t d, t;
      logic [98:0] gp;
      d = dr.meta;
      t = tr.meta;
      gp = {3'b001, 96'h0};
      if (!env.in_enclave || ba[5:0] != 0 || ct[11:0] != 0 || (env.mode64 ?
         ba[63:47] != {17{ba[47]}} : ct + 64'hfff > env.seg_limit))
         return gp;
      if (ba < env.el_base || ba + 64'h3f > env.el_limit || ct < env.el_base ||
         ct + 64'hfff > env.el_limit) return gp;
      if (dr.pf) return {3'b010, ba, dr.pf_code};
      if (!dr.in_epc) return {3'b010, ba, 32'h0};
      if (!tr.in_epc) return {3'b010, ct, 32'h0};
      if (!d.valid || !d.r || d.pending || d.modified || d.blocked || d.owner != env.active ||
         d.pt != perm_ext_pkg::REGULAR_PAGE_TYPE || d.lin != {ba[63:12], 12'h0})
         return {3'b010, ba, 32'h0};
      if ((dr.data & perm_ext_pkg::DESC_RSV_MASK) != 0) return gp;
      if (!t.valid || t.pending || t.modified || t.blocked || t.pt != d.pt ||
         t.owner != env.active) return {3'b010, ct, 32'h0};
      if (lb) return gp;
      if (t.lin != ct) return {3'b010, ct, 32'h0};
      if (!t.r && dr.data[1:0] == 2'b10) return gp;
      return {3'b100, 96'h0};
   endfunction
   task automatic issue(input logic [63:0] sel);
      @(posedge sys_clk_i);
      env_i <= env;
      leaf_i <= {sel, ba, ct};
      leaf_req_i <= 1'b1;
      @(posedge sys_clk_i);
      leaf_req_i <= 1'b0;
      #1;
   endtask
   task automatic run_leaf(input int id);
      logic [98:0] e;
      logic [2:0] rwx;
      int n, wr;
      e = expect_of();
      rwx = 3'h0;
      wr = 0;
      n = 0;
      issue(perm_ext_pkg::LEAF_EXTEND);
      while (done_o !== 1'b1 && gp_o !== 1'b1 && pf_o !== 1'b1 && n < 300) begin
         @(posedge sys_clk_i);
         #1;
         if (meta_wr_o === 1'b1) begin
            wr++;
            rwx = meta_rwx_o;
         end
         n++;
      end
      bound(n);
      chk_val("result", e[98:96], {done_o, pf_o, gp_o});
      chk_val("writes", e[98], wr);
      chk_val("rights", e[98] ? {tr.meta.x, tr.meta.w, tr.meta.r} | dr.data[2:0] : 3'h0,
         rwx);
      @(posedge sys_clk_i);
      #1;
      if (!e[98]) chk_val("fault address", e[95:32], fault_addr_o);
      if (!e[98]) chk_val("error code", e[31:0], err_code_o);
      n = 0;
      while (busy_o !== 1'b0 && n < 300) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      bound(n);
      $display("leaf %0d ends with %b", id, e[98:96]);
   endtask
   task automatic good();
      env = {2'b11, 32'hffff_ffff, 64'h1000_0000, 64'h1fff_ffff, 64'h00ab_c000};
      ba = 64'h1000_2040;
      ct = 64'h1000_5000;
      dr = '0;
      dr.in_epc = 1'b1;
      dr.pf_code = $random(seed);
      dr.meta = {7'b1100000, perm_ext_pkg::REGULAR_PAGE_TYPE, env.active, 64'h1000_2000};
      dr.data[15:0] = 16'($random(seed)) & 16'hff07;
      tr = dr;
      tr.meta.lin = ct;
      {tr.meta.r, tr.meta.w, tr.meta.x} = 3'($random(seed));
      lb = 1'b0;
      slow = 4'($random(seed));
   endtask
   initial begin
      errors = 0;
      tests_run = 0;
      seed = 32'hc1f3d235;
      {nrst_i, reg_wr_i, reg_rd_i, leaf_req_i, reg_addr_i, reg_wdata_i} = '0;
      leaf_i = '0;
      env_i = '0;
      good();
      repeat (20) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      reg_rd(perm_ext_pkg::REG_CTRL, 32'h1);
      reg_rd(perm_ext_pkg::REG_MASK, 32'h0);
      reg_rd(8'h40, 32'h0);
      issue(64'h5);
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk_val("busy", 1'b0, busy_o);
      reg_wr(perm_ext_pkg::REG_CTRL, 32'h0);
      issue(perm_ext_pkg::LEAF_EXTEND);
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk_val("busy", 1'b0, busy_o);
      reg_wr(perm_ext_pkg::REG_CTRL, 32'h1);
      for (int i = 0; i < 48; i++) begin
         good();
         k = (i < 16) ? i : {$random(seed)} % 16;
         case (k)
            0: env.in_enclave = 1'b0;
            1: ba[63] = 1'b1;
            2: ba[3] = 1'b1;
            3: ct[4] = 1'b1;
            4: ct = env.el_limit + 64'h1;
            5: dr.pf = 1'b1;
            6: dr.in_epc = 1'b0;
            7: tr.in_epc = 1'b0;
            8: dr.meta.blocked = 1'b1;
            9: dr.data[16] = 1'b1;
            10: tr.meta.pending = 1'b1;
            11: lb = 1'b1;
            12: tr.meta.lin = ct + 64'h1000;
            13: {tr.meta.r, dr.data[1:0]} = 3'b010;
            14: {env.mode64, env.seg_limit} = {1'b0, 32'h1000_4fff};
            default: ;
         endcase
         run_leaf(i);
      end
      reg_wr(perm_ext_pkg::REG_STATUS, 32'h7);
      good();
      run_leaf(99);
      reg_rd(perm_ext_pkg::REG_STATUS, 32'h1);
      chk_val("irq", 1'b0, irq_o);
      reg_wr(perm_ext_pkg::REG_MASK, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk_val("irq", 1'b1, irq_o);
      reg_wr(perm_ext_pkg::REG_STATUS, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk_val("irq", 1'b0, irq_o);
      reg_rd(perm_ext_pkg::REG_COUNT, 32'h0000_0031);
      nrst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      reg_rd(perm_ext_pkg::REG_MASK, 32'h0);
      reg_rd(perm_ext_pkg::REG_COUNT, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
